//--- rtl/dls_pkg.sv
package dls_pkg;
  localparam int DLS_WORD_W    = 8;
  localparam int DLS_UPPER_W   = 5;
  localparam int DLS_LOWER_W   = 3;
  localparam int DLS_UPPER_SEG = 31;
  localparam int DLS_LOWER_SEG = 7;
  localparam int DLS_BUF_DEPTH = 2;
  localparam int DLS_CLK_MHZ   = 100;
  localparam int DLS_MAX_MSPS  = 210;
  localparam logic [DLS_WORD_W-1:0] DLS_WORD_RST = 8'h00;
  localparam logic [DLS_UPPER_SEG-1:0] DLS_UPPER_RST = 31'h0000_0000;
  localparam logic [DLS_LOWER_SEG-1:0] DLS_LOWER_RST = 7'h00;

  typedef enum logic {DLS_FMT_BINARY, DLS_FMT_TWOS} dls_fmt_t;
endpackage

//--- rtl/dls_word_buffer.sv
`timescale 1ns/10ps
module dls_word_buffer
  import dls_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o  = (count_r != (PW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

//--- rtl/dls_segment_core.sv
`timescale 1ns/10ps
// Behaviour
// - The sample word is eight bits, straight binary or twos complement, top bit most significant.
// - The word is captured edge-triggered and the segment controls change only on a rising edge.
// - While awake a new sample is accepted every clock cycle with no bubbles, up to 210 MSPS.
// - The upper five bits become a 31-wide thermometer code whose ones count equals their value.
// - The lower three bits become a 7-wide thermometer code, each worth an eighth of an upper one.
// - While awake each segment goes to exactly one output: true when asserted, complement otherwise.
// - Each segment has matched true and complement drives that change on the same edge.
// - True weight is code/256 and complement weight is (255-code)/256 of full scale.
// - Code 255 steers every segment to the true side and none to the complement side.
// - The logic is purely edge triggered and so works at any clock duty cycle.
// - A static format input selects straight binary when low and twos complement when high.
// - A high sleep input powers down and turns both output currents off; low keeps it enabled.
module dls_segment_core
  import dls_pkg::*;
#(
  parameter int WORD_W = DLS_WORD_W
)(
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [WORD_W-1:0]        sample_i,
  input  wire logic                     sample_valid_i,
  output logic                          sample_ready_o,
  input  wire logic                     format_twos_i,
  input  wire logic                     sleep_i,
  output logic      [DLS_UPPER_SEG-1:0] upper_true_o,
  output logic      [DLS_UPPER_SEG-1:0] upper_comp_o,
  output logic      [DLS_LOWER_SEG-1:0] lower_true_o,
  output logic      [DLS_LOWER_SEG-1:0] lower_comp_o,
  output logic      [WORD_W-1:0]        true_weight_o,
  output logic      [WORD_W-1:0]        comp_weight_o,
  output logic                          powered_down_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Thermometer decode, shared by both segment groups.

  function automatic logic [DLS_UPPER_SEG-1:0] therm(input logic [DLS_UPPER_W-1:0] v);
    logic [DLS_UPPER_SEG-1:0] t;
    t = '0;
    for (int i = 0; i < DLS_UPPER_SEG; i++)
    begin
      t[i] = (32'(v) > i);
    end
    therm = t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input buffer. The core drains a word every cycle, so the buffer only
  // fills when the core is held asleep; then it back-pressures the source.

  logic              buf_valid;
  logic [WORD_W-1:0] buf_data;
  logic              core_take;

  dls_word_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (DLS_BUF_DEPTH)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .in_data_i   (sample_i),
    .out_valid_o (buf_valid),
    .out_ready_i (!sleep_i),
    .out_data_o  (buf_data)
  );

  assign core_take = buf_valid && !sleep_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample register and format mapping.

  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] code;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      word_r <= DLS_WORD_RST;
    end
    else if (core_take)
    begin
      word_r <= buf_data;
    end
  end

  // Flipping the top bit maps signed codes onto the unsigned weights.
  assign code = (dls_fmt_t'(format_twos_i) == DLS_FMT_TWOS)
              ? {~word_r[WORD_W-1], word_r[WORD_W-2:0]}
              : word_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Segment outputs, registered so true and complement leave from the same edge.

  logic [DLS_UPPER_SEG-1:0] up_nxt;
  logic [DLS_LOWER_SEG-1:0] lo_nxt;
  logic                     sleep_r;

  assign up_nxt = therm(code[WORD_W-1 -: DLS_UPPER_W]);
  assign lo_nxt = DLS_LOWER_SEG'(therm(DLS_UPPER_W'(code[DLS_LOWER_W-1:0])));

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      upper_true_o  <= DLS_UPPER_RST;
      upper_comp_o  <= DLS_UPPER_RST;
      lower_true_o  <= DLS_LOWER_RST;
      lower_comp_o  <= DLS_LOWER_RST;
      true_weight_o <= '0;
      comp_weight_o <= '0;
      sleep_r       <= 1'b1;
    end
    else
    begin
      sleep_r <= sleep_i;
      if (sleep_i)
      begin
        upper_true_o  <= '0;
        upper_comp_o  <= '0;
        lower_true_o  <= '0;
        lower_comp_o  <= '0;
        true_weight_o <= '0;
        comp_weight_o <= '0;
      end
      else
      begin
        upper_true_o  <= up_nxt;
        upper_comp_o  <= ~up_nxt;
        lower_true_o  <= lo_nxt;
        lower_comp_o  <= ~lo_nxt;
        true_weight_o <= code;
        comp_weight_o <= ~code;
      end
    end
  end

  assign powered_down_o = sleep_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_pair_exclusive: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_r |-> ((upper_true_o ^ upper_comp_o) == '1) && ((lower_true_o ^ lower_comp_o) == '1))
    else $error("segment pair not complementary");

  a_upper_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_i |=> $countones(upper_true_o) == 32'($past(code[WORD_W-1 -: DLS_UPPER_W])))
    else $error("upper segment count wrong");

  a_lower_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_i |=> $countones(lower_true_o) == 32'($past(code[DLS_LOWER_W-1:0])))
    else $error("lower segment count wrong");

  a_weight_sum: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_r |-> 8*$countones(upper_true_o) + $countones(lower_true_o) == 32'(true_weight_o))
    else $error("true weight mismatch");

  a_full_scale: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (!sleep_i && code == 8'hff) |=> (upper_comp_o == '0) && (lower_comp_o == '0))
    else $error("full code not all true");

  a_sleep_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    sleep_i |=> (upper_true_o | upper_comp_o) == '0 && (lower_true_o | lower_comp_o) == '0)
    else $error("outputs active in sleep");

  a_twos_map: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (format_twos_i && !sleep_i) |=> true_weight_o == {~$past(word_r[WORD_W-1]),
                                                       $past(word_r[WORD_W-2:0])})
    else $error("twos complement mapping wrong");

  a_capture_each: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    core_take |=> word_r == $past(buf_data))
    else $error("sample not captured");

  a_stable_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (!sleep_i ##1 !sleep_i && $stable(code)) |=> $stable(upper_true_o) && $stable(lower_true_o))
    else $error("segments changed without new code");

  c_full: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_r && true_weight_o == 8'hff);
  c_zero: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !sleep_r && true_weight_o == 8'h00);
  c_stall: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    sample_valid_i && !sample_ready_o);
  c_twos: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    format_twos_i && core_take);
endmodule

//--- bench/dls_sample_source.sv
`timescale 1ns/10ps
module dls_sample_source
  import dls_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  offer_i,
  input  wire logic [DLS_WORD_W-1:0] word_i,
  input  wire logic                  ready_i,
  output logic                       valid_o,
  output logic      [DLS_WORD_W-1:0] data_o
);
  // An idle bus toggles so that a stale word never passes for a fresh one.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end
    else if (!valid_o || ready_i)
    begin
      valid_o <= offer_i;
      data_o  <= offer_i ? word_i : ~data_o;
    end
  end
endmodule

//--- bench/dac_input_latch_segment_decoder_tb.sv
`timescale 1ns/10ps
module dac_input_latch_segment_decoder_tb
  import dls_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        offer = 1'b0;
  logic        fmt = 1'b0;
  logic        sleep = 1'b0;
  logic        chk_on = 1'b0;
  logic [7:0]  word = 8'h00;
  logic [31:0] lfsr = 32'h0001_3c57;
  logic        valid, ready, pd, p1_v = 1'b0, p2_v = 1'b0, e_fmt = 1'b0;
  logic [7:0]  data, tw, cw, p1_d = 8'h00, p2_d = 8'h00, cur = 8'h00;
  logic [30:0] ut, uc;
  logic [6:0]  lt, lc;
  int          n_fail = 0, tests_run = 0, takes = 0, n0;
  wire  logic [92:0] seen_all = {ut, uc, lt, lc, tw, cw, pd};
  logic [7:0]  tbl [6] = '{8'hff, 8'h00, 8'hff, 8'h80, 8'h7f, 8'h01};

  always #5 ref_clk_i = ~ref_clk_i;

  dls_sample_source src_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .offer_i(offer),
    .word_i(word), .ready_i(ready), .valid_o(valid), .data_o(data));
  dls_segment_core #(.WORD_W(DLS_WORD_W)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .sample_i(data), .sample_valid_i(valid), .sample_ready_o(ready), .format_twos_i(fmt),
    .sleep_i(sleep), .upper_true_o(ut), .upper_comp_o(uc), .lower_true_o(lt),
    .lower_comp_o(lc), .true_weight_o(tw), .comp_weight_o(cw), .powered_down_o(pd));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [92:0] expect_all(input logic [7:0] w, input logic f);
    logic [7:0]  c;
    logic [30:0] u;
    logic [6:0]  l;
    c = f ? {~w[7], w[6:0]} : w;
    u = 31'((32'h1 << c[7:3]) - 32'h1);
    l = 7'((8'h1 << c[2:0]) - 8'h1);
    return {u, ~u, l, ~l, c, 8'hff - c, 1'b0};
  endfunction

  task automatic check(input string what, input logic [92:0] seen, input logic [92:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Outputs show a word two edges after its handshake, with the format of that edge.
  always @(posedge ref_clk_i)
  begin
    p1_v <= valid & ready;
    p1_d <= data;
    p2_v <= p1_v;
    p2_d <= p1_d;
    if (p2_v)
      cur <= p2_d;
    e_fmt <= fmt;
    if (valid & ready)
      takes <= takes + 1;
  end

  always @(negedge ref_clk_i)
    if (chk_on)
      check("segments", seen_all, expect_all(cur, e_fmt));

  initial
  begin
    repeat (19) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("reset outputs", seen_all, 93'h1);
    check("reset ready", ready, 93'h1);
    @(posedge ref_clk_i) reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk_on = 1'b1;
    repeat (600)
    begin
      @(posedge ref_clk_i);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      offer <= lfsr[0] | lfsr[1];
      word <= lfsr[15:8];
      fmt <= (lfsr[7:3] == 5'h00) ? ~fmt : fmt;
    end
    for (int i = 0; i < 12; i++)
    begin
      @(posedge ref_clk_i);
      offer <= 1'b1;
      word <= tbl[i % 6];
      fmt <= (i >= 6);
    end
    @(posedge ref_clk_i) offer <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk_on = 1'b0;
    sleep <= 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("sleep outputs", {ut, uc, lt, lc, pd}, 77'h1);
    n0 = takes;
    @(posedge ref_clk_i);
    offer <= 1'b1;
    word <= 8'h3c;
    for (int i = 0; i < 12 && (ready !== 1'b0 || i < 3); i++)
      @(posedge ref_clk_i);
    check("sleep refusal", takes - n0, 93'h2);
    check("sleep ready", ready, 93'h0);
    sleep <= 1'b0;
    offer <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk_on = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    final_report();
  end
endmodule
